// *** core/pdc_pkg.sv ***
package pdc_pkg;
    // Register byte addresses on the bus
    localparam logic [3:0] PDC_PWR_CTRL_ADDR = 4'h0; // power_control_reg
    localparam logic [3:0] PDC_IO_CTRL_ADDR = 4'h4;  // io_control_reg
    localparam logic [3:0] PDC_STATUS_ADDR = 4'h8;
    localparam logic [3:0] PDC_PORT01_ADDR = 4'hc;
    // Field positions
    localparam int PDC_SOFT_BIT = 1;
    localparam int PDC_ARM_BIT = 6;
    localparam int PDC_FLOAT_BIT = 0;
    localparam int PDC_EXT_PROG_BIT = 1;
    localparam int PDC_FAIL_PIN = 5;
    // Reset values
    localparam logic [7:0] PDC_PWR_CTRL_RST = 8'h00;
    localparam logic [7:0] PDC_IO_CTRL_RST = 8'h00;
    localparam logic [7:0] PDC_PORT_RST = 8'hff;
    // Port 3 pins kept as inputs when floating, per mode
    localparam logic [7:0] PDC_P3_KEEP_SOFT = 8'h3c;
    localparam logic [7:0] PDC_P3_KEEP_HARD = 8'h3c;
    localparam logic [7:0] PDC_P3_FAIL_MASK = 8'h20;

    typedef enum {PDC_RUN, PDC_SOFT, PDC_HARD} pdc_mode_t;

    // One 8-bit port: pin data and active-low drive enable
    typedef struct packed {
        logic [7:0] dout;
        logic [7:0] oe_n;
    } pdc_port_t;
endpackage : pdc_pkg

// *** core/pdc_top.sv ***
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module pdc_top (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    // Avalon-MM slave
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    // Pins from the board
    input wire logic [7:0] P3_PIN_I,
    input wire logic EXT_PROG_SEL_I,
    // Port pins (oe_n low while driving)
    output pdc_pkg::pdc_port_t PORT0_O,
    output pdc_pkg::pdc_port_t PORT1_O,
    output pdc_pkg::pdc_port_t PORT2_O,
    output pdc_pkg::pdc_port_t PORT3_O,
    // Strobes and core controls
    output logic PROG_FETCH_STROBE_O,
    output logic ADDR_LATCH_STROBE_O,
    output logic OSC_RUN_O,
    output logic CORE_HALT_O,
    output logic TIMER_EXT_ONLY_O
);
    import pdc_pkg::*;

    // Three-stage pin synchronisers
    logic [7:0] p3_s1_r;
    logic [7:0] p3_s2_r;
    logic [7:0] p3_s3_r;
    logic ext_s1_r;
    logic ext_s2_r;
    logic ext_s3_r;
    // Agreed levels after stages two and three match
    logic fail_stable_r;
    logic fail_stable_nxt;
    logic ext_stable_r;
    logic ext_stable_nxt;
    // Software registers and port latches
    logic [7:0] pwr_ctrl_r;
    logic [7:0] pwr_ctrl_nxt;
    logic [7:0] io_ctrl_r;
    logic [7:0] io_ctrl_nxt;
    logic [7:0] latch0_r;
    logic [7:0] latch0_nxt;
    logic [7:0] latch1_r;
    logic [7:0] latch1_nxt;
    logic [7:0] latch2_r;
    logic [7:0] latch2_nxt;
    logic [7:0] latch3_r;
    logic [7:0] latch3_nxt;
    // Bus answer
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic wait_r;
    logic wait_nxt;
    logic wr_hit;
    logic rd_hit;
    // Mode and the float choice held at entry
    pdc_mode_t mode_r;
    pdc_mode_t mode_nxt;
    logic float_held_r;
    logic float_held_nxt;
    logic fail_fall;
    // Registered pin and control outputs
    pdc_port_t p0_r;
    pdc_port_t p0_nxt;
    pdc_port_t p1_r;
    pdc_port_t p1_nxt;
    pdc_port_t p2_r;
    pdc_port_t p2_nxt;
    pdc_port_t p3_r;
    pdc_port_t p3_nxt;
    logic fetch_strb_r;
    logic fetch_strb_nxt;
    logic ale_r;
    logic ale_nxt;
    logic osc_r;
    logic osc_nxt;
    logic halt_r;
    logic halt_nxt;
    logic tmr_r;
    logic tmr_nxt;

    // Byte-lane merge for writes
    function automatic logic [7:0] pdc_lane(input logic [7:0] old, input logic [7:0] wd,
                                            input logic be);
        pdc_lane = be ? wd : old;
    endfunction : pdc_lane

    // Drive or float a whole port, keeping some pins as inputs
    function automatic pdc_port_t pdc_drive(input logic [7:0] d, input logic [7:0] flt);
        pdc_port_t res;
        // Floating pins show zero so no stale latch value leaks out
        res.dout = d & ~flt;
        res.oe_n = flt;
        return res;
    endfunction : pdc_drive

    // Mode decode shared by the status word and the pin logic
    function automatic logic pdc_is_hard(input pdc_mode_t m);
        return m == PDC_HARD;
    endfunction : pdc_is_hard

    // Synchronisers; first stage feeds only the second
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            p3_s1_r <= PDC_PORT_RST;
            p3_s2_r <= PDC_PORT_RST;
            p3_s3_r <= PDC_PORT_RST;
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end else begin
            p3_s1_r <= P3_PIN_I;
            p3_s2_r <= p3_s1_r;
            p3_s3_r <= p3_s2_r;
            ext_s1_r <= EXT_PROG_SEL_I;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    // A change counts once stages two and three agree
    always_comb begin
        fail_stable_nxt = fail_stable_r;
        ext_stable_nxt = ext_stable_r;
        if (p3_s2_r[PDC_FAIL_PIN] == p3_s3_r[PDC_FAIL_PIN]) begin
            fail_stable_nxt = p3_s3_r[PDC_FAIL_PIN];
        end
        if (ext_s2_r == ext_s3_r) begin
            ext_stable_nxt = ext_s3_r;
        end
    end

    // Agreed levels; fail level resets high so reset gives no false fall
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            fail_stable_r <= 1'b1;
            ext_stable_r <= 1'b0;
        end else begin
            fail_stable_r <= fail_stable_nxt;
            ext_stable_r <= ext_stable_nxt;
        end
    end

    assign fail_fall = fail_stable_r & ~fail_stable_nxt;
    // Write lands only at the edge where the master sees waitrequest low
    assign wr_hit = AVS_WRITE_I & ~wait_r;
    // Read data loaded one edge early so it stands at that edge
    assign rd_hit = AVS_READ_I & wait_r;

    // Register file and bus answer
    always_comb begin
        pwr_ctrl_nxt = pwr_ctrl_r;
        io_ctrl_nxt = io_ctrl_r;
        latch0_nxt = latch0_r;
        latch1_nxt = latch1_r;
        latch2_nxt = latch2_r;
        latch3_nxt = latch3_r;
        rdata_nxt = rdata_r;
        // One wait cycle, then the answer edge; waitrequest rises again after it
        wait_nxt = !((AVS_READ_I || AVS_WRITE_I) && wait_r);
        if (wr_hit) begin
            case (AVS_ADDRESS_I)
                PDC_PWR_CTRL_ADDR: begin
                    pwr_ctrl_nxt = pdc_lane(pwr_ctrl_r, AVS_WRITEDATA_I[7:0],
                                            AVS_BYTEENABLE_I[0]);
                end
                PDC_IO_CTRL_ADDR: begin
                    io_ctrl_nxt = pdc_lane(io_ctrl_r, AVS_WRITEDATA_I[7:0],
                                           AVS_BYTEENABLE_I[0]);
                end
                PDC_PORT01_ADDR: begin
                    latch0_nxt = pdc_lane(latch0_r, AVS_WRITEDATA_I[7:0], AVS_BYTEENABLE_I[0]);
                    latch1_nxt = pdc_lane(latch1_r, AVS_WRITEDATA_I[15:8], AVS_BYTEENABLE_I[1]);
                    latch2_nxt = pdc_lane(latch2_r, AVS_WRITEDATA_I[23:16], AVS_BYTEENABLE_I[2]);
                    latch3_nxt = pdc_lane(latch3_r, AVS_WRITEDATA_I[31:24], AVS_BYTEENABLE_I[3]);
                end
                default: begin
                end
            endcase
        end
        if (rd_hit) begin
            case (AVS_ADDRESS_I)
                PDC_PWR_CTRL_ADDR: rdata_nxt = {24'h000000, pwr_ctrl_r};
                PDC_IO_CTRL_ADDR: rdata_nxt = {24'h000000, io_ctrl_r};
                PDC_STATUS_ADDR: rdata_nxt = {28'h0000000, fail_stable_r, float_held_r,
                                              pdc_is_hard(mode_r), mode_r == PDC_SOFT};
                PDC_PORT01_ADDR: rdata_nxt = {latch3_r, latch2_r, latch1_r, latch0_r};
                default: rdata_nxt = 32'h00000000;
            endcase
        end
    end

    // Bus and register state
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            pwr_ctrl_r <= PDC_PWR_CTRL_RST;
            io_ctrl_r <= PDC_IO_CTRL_RST;
            latch0_r <= PDC_PORT_RST;
            latch1_r <= PDC_PORT_RST;
            latch2_r <= PDC_PORT_RST;
            latch3_r <= PDC_PORT_RST;
            rdata_r <= 32'h00000000;
            wait_r <= 1'b1;
        end else begin
            pwr_ctrl_r <= pwr_ctrl_nxt;
            io_ctrl_r <= io_ctrl_nxt;
            latch0_r <= latch0_nxt;
            latch1_r <= latch1_nxt;
            latch2_r <= latch2_nxt;
            latch3_r <= latch3_nxt;
            rdata_r <= rdata_nxt;
            wait_r <= wait_nxt;
        end
    end

    // Mode sequencing; hard entry wins over a soft request in the same cycle
    always_comb begin
        mode_nxt = mode_r;
        float_held_nxt = float_held_r;
        case (mode_r)
            PDC_RUN: begin
                // armed fall enters hard mode; arm comes from software
                if (pwr_ctrl_r[PDC_ARM_BIT] && fail_fall) begin
                    mode_nxt = PDC_HARD;
                    float_held_nxt = io_ctrl_r[PDC_FLOAT_BIT];
                end else if (pwr_ctrl_r[PDC_SOFT_BIT]) begin
                    mode_nxt = PDC_SOFT;
                    float_held_nxt = io_ctrl_r[PDC_FLOAT_BIT];
                end
            end
            // Left only by reset, wake logic lies outside this block
            PDC_SOFT: mode_nxt = PDC_SOFT;
            PDC_HARD: mode_nxt = PDC_HARD;
            default: mode_nxt = PDC_RUN;
        endcase
    end

    // Mode state; only reset leaves a power-down mode
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            mode_r <= PDC_RUN;
            float_held_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            float_held_r <= float_held_nxt;
        end
    end

    // Pin states per mode
    always_comb begin
        logic ext_prog;
        ext_prog = ext_stable_r;
        p0_nxt = pdc_drive(latch0_r, 8'h00);
        p1_nxt = pdc_drive(latch1_r, 8'h00);
        p2_nxt = pdc_drive(latch2_r, 8'h00);
        p3_nxt = pdc_drive(latch3_r, 8'h00);
        // Run levels: strobes idle high, oscillator on, core free
        fetch_strb_nxt = 1'b1;
        ale_nxt = 1'b1;
        osc_nxt = 1'b1;
        halt_nxt = 1'b0;
        tmr_nxt = 1'b0;
        if (mode_nxt != PDC_RUN) begin
            osc_nxt = 1'b0;
            halt_nxt = 1'b1;
            tmr_nxt = 1'b1;
            fetch_strb_nxt = 1'b0;
            ale_nxt = 1'b0;
            if (!float_held_nxt) begin
                // keep driving latches; port 0 floats if external program, port 3 fail pin floats in hard mode
                p0_nxt = pdc_drive(latch0_r, ext_prog ? 8'hff : 8'h00);
                if (pdc_is_hard(mode_nxt)) begin
                    p3_nxt = pdc_drive(latch3_r, PDC_P3_FAIL_MASK);
                end
            end else begin
                p0_nxt = pdc_drive(latch0_r, 8'hff);
                p1_nxt = pdc_drive(latch1_r, 8'hff);
                p2_nxt = pdc_drive(latch2_r, 8'hff);
                p3_nxt = pdc_drive(latch3_r, 8'hff);
                if (pdc_is_hard(mode_nxt)) begin
                    p3_nxt.oe_n = p3_nxt.oe_n | PDC_P3_KEEP_HARD;
                end else begin
                    p3_nxt.oe_n = p3_nxt.oe_n | PDC_P3_KEEP_SOFT;
                end
            end
        end
    end

    // Pin and control registers
    // Loaded from the next mode, so pins change on the entry edge itself
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            p0_r <= '{dout: PDC_PORT_RST, oe_n: 8'h00};
            p1_r <= '{dout: PDC_PORT_RST, oe_n: 8'h00};
            p2_r <= '{dout: PDC_PORT_RST, oe_n: 8'h00};
            p3_r <= '{dout: PDC_PORT_RST, oe_n: 8'h00};
            fetch_strb_r <= 1'b1;
            ale_r <= 1'b1;
            osc_r <= 1'b1;
            halt_r <= 1'b0;
            tmr_r <= 1'b0;
        end else begin
            p0_r <= p0_nxt;
            p1_r <= p1_nxt;
            p2_r <= p2_nxt;
            p3_r <= p3_nxt;
            fetch_strb_r <= fetch_strb_nxt;
            ale_r <= ale_nxt;
            osc_r <= osc_nxt;
            halt_r <= halt_nxt;
            tmr_r <= tmr_nxt;
        end
    end

    // Outputs straight from their flip-flops
    assign AVS_READDATA_O = rdata_r;
    assign AVS_WAITREQUEST_O = wait_r;
    assign PORT0_O = p0_r;
    assign PORT1_O = p1_r;
    assign PORT2_O = p2_r;
    assign PORT3_O = p3_r;
    assign PROG_FETCH_STROBE_O = fetch_strb_r;
    assign ADDR_LATCH_STROBE_O = ale_r;
    assign OSC_RUN_O = osc_r;
    assign CORE_HALT_O = halt_r;
    assign TIMER_EXT_ONLY_O = tmr_r;
endmodule : pdc_top

// *** test/pdc_props.sv ***
`timescale 1ns/1ps
module pdc_props (
    // Clock, reset and bus
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic AVS_WAITREQUEST_O,
    // Pins and core controls
    input wire logic [7:0] P3_PIN_I,
    input wire logic EXT_PROG_SEL_I,
    input wire pdc_pkg::pdc_port_t PORT0_O,
    input wire pdc_pkg::pdc_port_t PORT1_O,
    input wire pdc_pkg::pdc_port_t PORT2_O,
    input wire pdc_pkg::pdc_port_t PORT3_O,
    input wire logic PROG_FETCH_STROBE_O,
    input wire logic ADDR_LATCH_STROBE_O,
    input wire logic OSC_RUN_O,
    input wire logic CORE_HALT_O
);
    import pdc_pkg::*;
    logic arm_r;
    logic arm_nxt;
    logic pwr_wr;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    // Arm bit as last written; byte lanes assumed all enabled
    always_comb begin
        pwr_wr = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == PDC_PWR_CTRL_ADDR;
        arm_nxt = pwr_wr ? AVS_WRITEDATA_I[PDC_ARM_BIT] : arm_r;
    end
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) arm_r <= 1'b0;
        else arm_r <= arm_nxt;
    end
    // Entry figures allow for the three-flop pin synchroniser
    property p_hard_entry;
        OSC_RUN_O && arm_r && $fell(P3_PIN_I[PDC_FAIL_PIN]) |-> ##[1:8] !OSC_RUN_O;
    endproperty
    a_hard_entry: assert property (p_hard_entry) else $error("no hard entry on fail");
    property p_soft_entry;
        pwr_wr && AVS_WRITEDATA_I[PDC_SOFT_BIT] |-> ##[1:3] !OSC_RUN_O;
    endproperty
    a_soft_entry: assert property (p_soft_entry) else $error("no soft entry");
    property p_halt; $fell(OSC_RUN_O) |-> $rose(CORE_HALT_O); endproperty
    a_halt: assert property (p_halt) else $error("core not halted with osc");
    property p_hold; CORE_HALT_O |=> CORE_HALT_O && $stable(PORT1_O.oe_n); endproperty
    a_hold: assert property (p_hold) else $error("power-down state moved");
    property p_strobes; CORE_HALT_O |-> !PROG_FETCH_STROBE_O && !ADDR_LATCH_STROBE_O; endproperty
    a_strobes: assert property (p_strobes) else $error("strobe high in power-down");
    property p_keep_in;
        CORE_HALT_O && PORT1_O.oe_n == 8'hff |-> PORT3_O.oe_n[5:2] == 4'hf;
    endproperty
    a_keep_in: assert property (p_keep_in) else $error("wake pin driven");
    property p_quiet; CORE_HALT_O && PORT2_O.oe_n == 8'hff |-> PORT2_O.dout == 8'h00; endproperty
    a_quiet: assert property (p_quiet) else $error("floating port data not zero");
    property p_port0; CORE_HALT_O && PORT1_O.oe_n == 8'h00 |-> PORT0_O.oe_n == {8{EXT_PROG_SEL_I}};
    endproperty
    a_port0: assert property (p_port0) else $error("port 0 drive wrong");
endmodule : pdc_props
bind pdc_top pdc_props u_props (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
    .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .P3_PIN_I(P3_PIN_I), .EXT_PROG_SEL_I(EXT_PROG_SEL_I),
    .PORT0_O(PORT0_O), .PORT1_O(PORT1_O), .PORT2_O(PORT2_O), .PORT3_O(PORT3_O),
    .PROG_FETCH_STROBE_O(PROG_FETCH_STROBE_O), .ADDR_LATCH_STROBE_O(ADDR_LATCH_STROBE_O),
    .OSC_RUN_O(OSC_RUN_O), .CORE_HALT_O(CORE_HALT_O));

// *** test/pdc_board.sv ***
`timescale 1ns/1ps
module pdc_board (
    // Detector and port 3 drive
    input wire logic fail_i,
    input wire pdc_pkg::pdc_port_t port3_i,
    // Pin levels seen by the block
    output logic [7:0] pins_o
);
    // pull-ups, detector pulls fail pin low (wired-AND)
    assign pins_o = (port3_i.dout | port3_i.oe_n) & ~{2'h0, fail_i, 5'h0};
endmodule : pdc_board

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import pdc_pkg::*;
    typedef struct packed {
        logic flt;
        logic ext;
        logic hard;
        logic [31:0] oe;
    } pdc_row_t;
    // Port 3 byte keeps bit 5 high so soft rows see no fail level
    localparam logic [31:0] LATCH = 32'h3c5a_96a5;
    pdc_row_t rows [8] = '{'{1'b0, 1'b0, 1'b0, 32'h0000_0000}, '{1'b0, 1'b1, 1'b0, 32'h0000_00ff},
        '{1'b0, 1'b0, 1'b1, 32'h2000_0000}, '{1'b0, 1'b1, 1'b1, 32'h2000_00ff},
        '{1'b1, 1'b0, 1'b0, 32'hffff_ffff}, '{1'b1, 1'b1, 1'b0, 32'hffff_ffff},
        '{1'b1, 1'b0, 1'b1, 32'hffff_ffff}, '{1'b1, 1'b1, 1'b1, 32'hffff_ffff}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, q, exp_w;
    logic wait_o, pfs, als, osc, halt, tmr;
    logic fail = 1'b0;
    logic ext = 1'b0;
    logic [7:0] pins;
    pdc_port_t p0, p1, p2, p3;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    pdc_top dut_u (.CLK_I(clk), .RESET_N_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_o), .P3_PIN_I(pins),
        .EXT_PROG_SEL_I(ext), .PORT0_O(p0), .PORT1_O(p1), .PORT2_O(p2), .PORT3_O(p3),
        .PROG_FETCH_STROBE_O(pfs), .ADDR_LATCH_STROBE_O(als), .OSC_RUN_O(osc),
        .CORE_HALT_O(halt), .TIMER_EXT_ONLY_O(tmr));
    pdc_board board_u (.fail_i(fail), .port3_i(p3), .pins_o(pins));
    always #50 clk = ~clk;
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // One Avalon access; held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        while (wait_o !== 1'b0) @(posedge clk);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic go_reset(input logic e);
        rst_n <= 1'b0;
        fail <= 1'b0;
        ext <= e;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask : go_reset
    initial begin
        foreach (rows[i]) begin
            go_reset(rows[i].ext);
            bus(1'b1, PDC_PORT01_ADDR, LATCH);
            bus(1'b1, PDC_IO_CTRL_ADDR, {31'h0, rows[i].flt});
            bus(1'b1, PDC_PWR_CTRL_ADDR, rows[i].hard ? 32'h40 : 32'h02);
            fail <= rows[i].hard;
            while (halt !== 1'b1) @(posedge clk);
            bus(1'b1, PDC_IO_CTRL_ADDR, {31'h0, !rows[i].flt});
            bus(1'b0, PDC_STATUS_ADDR, 32'h0);
            exp_w = {28'h0, !rows[i].hard, rows[i].flt, rows[i].hard, !rows[i].hard};
            chk("status", exp_w, q);
            chk("oe", rows[i].oe, {p3.oe_n, p2.oe_n, p1.oe_n, p0.oe_n});
            chk("dout", LATCH & ~rows[i].oe, {p3.dout, p2.dout, p1.dout, p0.dout});
            chk("ctl", 32'h03, {27'h0, osc, pfs, als, halt, tmr});
        end
        // Fail pin falls with the arm bit clear: must stay running
        go_reset(1'b0);
        // Reset must leave power-down with every port driving again
        chk("rst_ctl", 32'h1c, {27'h0, osc, pfs, als, halt, tmr});
        chk("rst_oe", 32'h0, {p3.oe_n, p2.oe_n, p1.oe_n, p0.oe_n});
        bus(1'b0, PDC_PWR_CTRL_ADDR, 32'h0);
        chk("pwr_rst", {24'h0, PDC_PWR_CTRL_RST}, q);
        fail <= 1'b1;
        repeat (10) @(posedge clk);
        chk("no_entry", 32'h1c, {27'h0, osc, pfs, als, halt, tmr});
        bus(1'b0, PDC_PORT01_ADDR, 32'h0);
        chk("latch_rst", {4{PDC_PORT_RST}}, q);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, q);
        report_and_stop();
    end
endmodule : testbench
